// *** rtl/rtc_calendar_alarm_regs.sv ***
/*
  Time, calendar and alarm core of a real-time clock with an AXI4-Lite
  register slave, a read snapshot, a write buffer and an alarm flag.
  Assumes one 250 MHz clock, a synchronous active-low reset and a master
  that follows the AXI4-Lite handshake rules.
*/
// Our own choice: the AXI4-Lite register port.
// What this block does
// - All time fields are stored as BCD.
// - Seconds and minutes count 00 to 59, wrap.
// - Hours 01-12 or 00-23 by mode.
// - Format bit: 0 twelve-hour, 1 twenty-four-hour.
// - Meridiem bit set means afternoon, 81-92.
// - Weekday counts 1 to 7, wraps to 1.
// - Day of month counts 01 to 31.
// - Month counts 01 to 12, wraps to 01.
// - Year counts BCD 00 to 99.
// - Time advances once every second.
// - Isolate clear: accesses reach live registers.
// - Isolate rising snapshots time for reads.
// - Isolate set buffers writes; clearing transfers them.
// - Alarm compares four fields, each ignorable.
// - Hours alarm C0-FF means hour ignored.
// - Weekday and day alarm share one register.
// - Day alarm bits 6-4 weekday, bit 7 any.
// - Leap years handled through year 2099.
// - Alarm bits 7 and 6 set ignore field.
// - Alarm match sets flag without any enable.
`timescale 1ns/1ps
module rtc_calendar_alarm_regs
  import rtc_pkg::*;
#(
  parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic alarm_flag
);

  // ****************************************
  // Helper functions.
  // ****************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == DIGIT_9) ? {v[7:4] + 4'h1, 4'h0}
                                   : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] mon,
                                          input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    if (mon == MON_FEB) begin
      last_day = leap ? BCD_29 : BCD_28;
    end else if (mon == MON_APR || mon == MON_JUN ||
                 mon == MON_SEP || mon == MON_NOV) begin
      last_day = BCD_30;
    end else begin
      last_day = BCD_31;
    end
  endfunction

  // ****************************************
  // State.
  // ****************************************
  logic [7:0] live [N_REG];
  logic [7:0] rbuf [N_REG];
  logic [7:0] wbuf [N_REG];
  logic [7:0] next_time [N_REG];
  logic [N_REG-1:0] written;
  logic isolate;
  logic hour_format_select;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic aw_held;
  logic [13:0] aw_idx;
  logic w_held;
  logic [7:0] w_byte;
  logic w_lane0;

  // ****************************************
  // One-second enable.
  // ****************************************
  wire tick_last = tick_cnt == TICK_W'(TICK_COUNT - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_last ? '0 : tick_cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= tick_last;
    end
  end

  // ****************************************
  // Time and calendar advance.
  // ****************************************
  wire [7:0] sec = live[S_SEC];
  wire [7:0] min = live[S_MIN];
  wire [7:0] hour = live[S_HOUR];
  wire [7:0] dayw = live[S_DAYW];
  wire [7:0] daym = live[S_DAYM];
  wire [7:0] mon = live[S_MONTH];
  wire [7:0] yr = live[S_YEAR];

  wire wrap_s = sec >= BCD_59;
  wire [7:0] n_sec = wrap_s ? BCD_00 : bcd_inc(sec);
  wire wrap_m = min >= BCD_59;
  wire c_hour = wrap_s & wrap_m;
  wire [7:0] n_min = !wrap_s ? min : wrap_m ? BCD_00 : bcd_inc(min);

  wire pm = hour[MERIDIEM_BIT];
  wire [7:0] h = {1'b0, hour[6:0]};
  wire [7:0] h_inc = bcd_inc(h);
  wire end_24 = h >= BCD_23;
  wire end_12 = (h == BCD_11) & pm;
  wire [7:0] hr24 = end_24 ? BCD_00 : h_inc;
  wire [7:0] hr12 = (h >= BCD_12) ? {pm, BCD_01[6:0]}
                  : (h == BCD_11) ? {~pm, BCD_12[6:0]}
                  : {pm, h_inc[6:0]};
  wire [7:0] n_hour = !c_hour ? hour
                    : hour_format_select ? hr24 : hr12;
  wire c_day = c_hour & (hour_format_select ? end_24 : end_12);

  wire [2:0] wd = dayw[2:0];
  wire [2:0] wd_inc = (wd >= WDAY_LAST) ? WDAY_FIRST : wd + 3'h1;
  wire [2:0] n_wd = c_day ? wd_inc : wd;

  wire wrap_d = daym >= last_day(mon, yr);
  wire [7:0] n_daym = !c_day ? daym
                    : wrap_d ? BCD_01 : bcd_inc(daym);
  wire c_mon = c_day & wrap_d;
  wire wrap_mo = mon >= BCD_12;
  wire [7:0] n_mon = !c_mon ? mon
                   : wrap_mo ? BCD_01 : bcd_inc(mon);
  wire c_yr = c_mon & wrap_mo;
  wire [7:0] n_yr = !c_yr ? yr
                  : (yr >= BCD_99) ? BCD_00 : bcd_inc(yr);

  assign next_time[S_SEC] = n_sec;
  assign next_time[S_SECA] = live[S_SECA];
  assign next_time[S_MIN] = n_min;
  assign next_time[S_MINA] = live[S_MINA];
  assign next_time[S_HOUR] = n_hour;
  assign next_time[S_HOURA] = live[S_HOURA];
  assign next_time[S_DAYW] = {dayw[7:3], n_wd};
  assign next_time[S_DAYM] = n_daym;
  assign next_time[S_MONTH] = n_mon;
  assign next_time[S_YEAR] = n_yr;

  // ****************************************
  // Alarm compare.
  // ****************************************
  wire [7:0] seca = live[S_SECA];
  wire [7:0] mina = live[S_MINA];
  wire [7:0] houra = live[S_HOURA];
  wire any_sec = seca[7:6] == IGNORE_CODE;
  wire any_min = mina[7:6] == IGNORE_CODE;
  wire any_hour = houra[7:6] == IGNORE_CODE;
  wire any_day = dayw[DAY_ANY_BIT];
  wire m_sec = any_sec | (seca == n_sec);
  wire m_min = any_min | (mina == n_min);
  wire m_hour = any_hour | (houra == n_hour);
  wire m_day = any_day | (dayw[6:4] == n_wd);
  wire match = tick & m_sec & m_min & m_hour & m_day;

  // ****************************************
  // Write channel decode.
  // ****************************************
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire wr_do = aw_held & w_held & ~s_axi_bvalid;
  wire [3:0] wr_slot = 4'(aw_idx - IDX_SEC);
  wire wr_slot_ok = (aw_idx >= IDX_SEC) && (aw_idx <= IDX_YEAR);
  wire wr_hit_ctrl = aw_idx == IDX_CTRL;
  wire wr_hit_stat = aw_idx == IDX_STAT;
  wire wr_ok = wr_slot_ok | wr_hit_ctrl | wr_hit_stat;
  wire wr_en = wr_do & w_lane0;
  wire [7:0] wr_mask = (wr_slot == S_DAYW) ? MASK_DAYW : MASK_FULL;
  wire [7:0] wr_val = w_byte & wr_mask;
  wire slot_wr = wr_en & wr_slot_ok;
  wire direct_wr = slot_wr & ~isolate;
  wire buf_wr = slot_wr & isolate;
  wire ctrl_wr = wr_en & wr_hit_ctrl;
  wire set_req = w_byte[CTRL_SET_BIT];
  wire snap = ctrl_wr & set_req & ~isolate;
  wire xfer = ctrl_wr & ~set_req & isolate;
  wire flag_clr = wr_en & wr_hit_stat & w_byte[STAT_FLAG_BIT];
  wire next_aw_held = aw_fire | (aw_held & ~wr_do);
  wire next_w_held = w_fire | (w_held & ~wr_do);
  wire next_bvalid = wr_do | (s_axi_bvalid & ~s_axi_bready);

  // ****************************************
  // Read channel decode.
  // ****************************************
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire [13:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire [3:0] rd_slot = 4'(rd_idx - IDX_SEC);
  wire rd_slot_ok = (rd_idx >= IDX_SEC) && (rd_idx <= IDX_YEAR);
  wire rd_alarm = (rd_slot == S_SECA) | (rd_slot == S_MINA) |
                  (rd_slot == S_HOURA);
  wire [7:0] rd_time = (isolate & ~rd_alarm) ? rbuf[rd_slot]
                                             : live[rd_slot];
  wire [7:0] rd_ctrl = {6'h00, hour_format_select, isolate};
  wire [7:0] rd_stat = {7'h00, alarm_flag};
  wire rd_hit_ctrl = rd_idx == IDX_CTRL;
  wire rd_hit_stat = rd_idx == IDX_STAT;
  wire rd_ok = rd_slot_ok | rd_hit_ctrl | rd_hit_stat;
  wire [7:0] rd_val = rd_slot_ok ? rd_time
                    : rd_hit_ctrl ? rd_ctrl
                    : rd_hit_stat ? rd_stat : 8'h00;
  wire next_rvalid = ar_fire | (s_axi_rvalid & ~s_axi_rready);

  // ****************************************
  // Register storage.
  // ****************************************
  always_ff @(posedge aclk) begin
    for (int i = 0; i < N_REG; i++) begin
      if (!aresetn) begin
        live[i] <= RST_VAL[i];
      end else if (xfer & written[i]) begin
        live[i] <= wbuf[i];
      end else if (direct_wr & (wr_slot == 4'(i))) begin
        live[i] <= wr_val;
      end else if (tick) begin
        live[i] <= next_time[i];
      end
    end
  end

  // ****************************************
  // Read snapshot and write buffer.
  // ****************************************

  always_ff @(posedge aclk) begin
    for (int i = 0; i < N_REG; i++) begin
      if (!aresetn) begin
        rbuf[i] <= RST_VAL[i];
      end else if (snap) begin
        rbuf[i] <= live[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < N_REG; i++) begin
      if (!aresetn) begin
        wbuf[i] <= RST_VAL[i];
      end else if (buf_wr & (wr_slot == 4'(i))) begin
        wbuf[i] <= wr_val;
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < N_REG; i++) begin
      if (!aresetn) begin
        written[i] <= 1'b0;
      end else if (buf_wr & (wr_slot == 4'(i))) begin
        written[i] <= 1'b1;
      end else if (xfer) begin
        written[i] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control bits and alarm flag.
  // ****************************************

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      isolate <= 1'b0;
      hour_format_select <= 1'b0;
    end else if (ctrl_wr) begin
      isolate <= set_req;
      hour_format_select <= w_byte[CTRL_FMT_BIT];
    end
  end

  // A match in the same cycle as a clear wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_flag <= 1'b0;
    end else begin
      alarm_flag <= match | (alarm_flag & ~flag_clr);
    end
  end

  // ****************************************
  // AXI4-Lite write side.
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= ~next_aw_held;
      s_axi_wready <= ~next_w_held;
      s_axi_bvalid <= next_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_idx <= '0;
    end else if (aw_fire) begin
      aw_idx <= s_axi_awaddr[ADDR_W-1:2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_byte <= '0;
      w_lane0 <= 1'b0;
    end else if (w_fire) begin
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ****************************************
  // AXI4-Lite read side.
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

endmodule

// *** rtl/rtc_pkg.sv ***
/*
  Constants for the real-time clock time, calendar and alarm core:
  register indices, storage slots, field positions, reset values, BCD
  limits and the one-second divider count.
  Assumes a 250 MHz register clock and 32-bit AXI4-Lite data.
*/
package rtc_pkg;

  // ****************************************
  // Register indices (byte address is four times the index).
  // ****************************************
  localparam logic [13:0] IDX_SEC = 14'h1800;
  localparam logic [13:0] IDX_SECA = 14'h1801;
  localparam logic [13:0] IDX_MIN = 14'h1802;
  localparam logic [13:0] IDX_MINA = 14'h1803;
  localparam logic [13:0] IDX_HOUR = 14'h1804;
  localparam logic [13:0] IDX_HOURA = 14'h1805;
  localparam logic [13:0] IDX_DAYW = 14'h1806;
  localparam logic [13:0] IDX_DAYM = 14'h1807;
  localparam logic [13:0] IDX_MONTH = 14'h1808;
  localparam logic [13:0] IDX_YEAR = 14'h1809;
  localparam logic [13:0] IDX_CTRL = 14'h180A;
  localparam logic [13:0] IDX_STAT = 14'h180B;
  localparam int ADDR_W = 16;

  // ****************************************
  // Storage slots, one per time, calendar or alarm register.
  // ****************************************
  localparam int N_REG = 10;
  localparam logic [3:0] S_SEC = 4'h0;
  localparam logic [3:0] S_SECA = 4'h1;
  localparam logic [3:0] S_MIN = 4'h2;
  localparam logic [3:0] S_MINA = 4'h3;
  localparam logic [3:0] S_HOUR = 4'h4;
  localparam logic [3:0] S_HOURA = 4'h5;
  localparam logic [3:0] S_DAYW = 4'h6;
  localparam logic [3:0] S_DAYM = 4'h7;
  localparam logic [3:0] S_MONTH = 4'h8;
  localparam logic [3:0] S_YEAR = 4'h9;

  // ****************************************
  // Field positions and masks.
  // ****************************************
  localparam int CTRL_SET_BIT = 0;
  localparam int CTRL_FMT_BIT = 1;
  localparam int STAT_FLAG_BIT = 0;
  localparam int MERIDIEM_BIT = 7;
  localparam int DAY_ANY_BIT = 7;
  localparam logic [1:0] IGNORE_CODE = 2'h3;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_DAYW = 8'hF7;

  // ****************************************
  // Reset values of the stored registers, by slot.
  // ****************************************
  localparam logic [7:0] RST_VAL [N_REG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h12,
    8'h00, 8'h01, 8'h01, 8'h01, 8'h00
  };

  // ****************************************
  // BCD limits.
  // ****************************************
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_28 = 8'h28;
  localparam logic [7:0] BCD_29 = 8'h29;
  localparam logic [7:0] BCD_30 = 8'h30;
  localparam logic [7:0] BCD_31 = 8'h31;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [3:0] DIGIT_9 = 4'h9;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [2:0] WDAY_FIRST = 3'h1;
  localparam logic [2:0] WDAY_LAST = 3'h7;

  // ****************************************
  // Timing and bus answers.
  // ****************************************
  localparam int SECOND_NS = 1000000000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** verif/rtc_regs_chk.sv ***
/*
  Checker for the clock core's register port and alarm flag.
  Bound to the core; it sees the core's ports only.
*/
`timescale 1ns/1ps
module rtc_regs_chk
  import rtc_pkg::*;
#(
  parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic alarm_flag
);
  int unsigned cyc;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // Bus answers and alarm flag.
  // ****************
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  property p_rd_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_flag_clr;
    $fell(alarm_flag) |-> $rose(s_axi_bvalid);
  endproperty
  property p_flag_tick;
    $rose(alarm_flag) |-> (cyc % TICK_COUNT) <= 2;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write answer late");
  a_b_once: assert property (p_b_once)
    else $error("write answer repeated");
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  a_r_once: assert property (p_r_once)
    else $error("read answer repeated");
  a_ar_busy: assert property (p_ar_busy)
    else $error("read taken while answering");
  a_err_zero: assert property (p_err_zero)
    else $error("error read carries data");
  a_rd_byte: assert property (p_rd_byte)
    else $error("read data upper bits set");
  a_flag_clr: assert property (p_flag_clr)
    else $error("alarm flag fell without a write");
  a_flag_tick: assert property (p_flag_tick)
    else $error("alarm flag rose off the tick");
  c_flag: cover property ($rose(alarm_flag));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// *** verif/tb_top.sv ***
/*
  Self-checking bench for the clock core over AXI4-Lite.
  Assumes a shortened second of TK cycles.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top
  import rtc_pkg::*;
;
  localparam int unsigned TK = 64;
  localparam logic [13:0] TIX [7] = '{IDX_SEC, IDX_MIN, IDX_HOUR,
    IDX_DAYW, IDX_DAYM, IDX_MONTH, IDX_YEAR};
  logic aclk;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = '0;
  logic [15:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, flag;
  logic [1:0] bresp, rresp, last_b, last_r;
  logic [31:0] rdata, last_d;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  rtc_calendar_alarm_regs #(.TICK_COUNT(TK)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .alarm_flag(flag));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end
  // ****************
  // Bus tasks.
  // ****************
  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w || bvalid !== 1'b1) begin
      @(posedge aclk);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    last_b = bresp;
  endtask
  task automatic rd(input logic [13:0] i);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (rvalid !== 1'b1) @(posedge aclk);
    last_d = rdata;
    last_r = rresp;
  endtask
  task automatic rc(input logic [13:0] i, input logic [7:0] e);
    rd(i);
    `CHK(last_d, {24'h0, e})
    `CHK(last_r, RESP_OKAY)
  endtask
  task automatic set_time(input logic [7:0] f, input logic [7:0] t [7]);
    wr(IDX_CTRL, f | 8'h01);
    for (int k = 0; k < 7; k++) wr(TIX[k], t[k]);
    wr(IDX_CTRL, f);
  endtask
  task automatic tick_wait(input logic [7:0] s);
    rd(IDX_SEC);
    while (last_d[7:0] === s) rd(IDX_SEC);
  endtask
  // ****************
  // Scenarios.
  // ****************
  task automatic roll(input logic [7:0] f, input logic [7:0] t [7],
                      input logic [7:0] e [7]);
    set_time(f, t);
    tick_wait(t[0]);
    wr(IDX_CTRL, f | 8'h01);
    for (int k = 0; k < 7; k++) rc(TIX[k], e[k]);
    repeat (TK + 8) @(posedge aclk);
    rc(IDX_SEC, e[0]);
    wr(IDX_CTRL, f);
  endtask
  task automatic reset_case();
    rc(IDX_SEC, 8'h00);
    rc(IDX_HOUR, 8'h12);
    rc(IDX_DAYW, 8'h01);
    rc(IDX_MONTH, 8'h01);
    wstrb <= 4'h0;
    wr(IDX_MIN, 8'h33);
    `CHK(last_b, RESP_OKAY)
    wstrb <= 4'h1;
    rc(IDX_MIN, 8'h00);
    rd(14'h1810);
    `CHK(last_r, RESP_SLVERR)
    `CHK(last_d, 32'h0)
    wr(14'h1810, 8'h5A);
    `CHK(last_b, RESP_SLVERR)
  endtask
  task automatic alarm_case();
    wr(IDX_SECA, 8'h05);
    wr(IDX_MINA, 8'hC0);
    wr(IDX_HOURA, 8'h11);
    set_time(8'h02, '{8'h04, 8'h20, 8'h10, 8'h33, 8'h15, 8'h06, 8'h10});
    tick_wait(8'h04);
    `CHK(flag, 1'b0)
    wr(IDX_SECA, 8'h06);
    wr(IDX_HOURA, 8'h10);
    tick_wait(8'h05);
    `CHK(flag, 1'b1)
    rc(IDX_STAT, 8'h01);
    wr(IDX_STAT, 8'h01);
    `CHK(flag, 1'b0)
    wr(IDX_HOURA, 8'hC5);
    wr(IDX_DAYW, 8'h83);
    wr(IDX_SECA, 8'h07);
    rc(IDX_DAYW, 8'h83);
    tick_wait(8'h06);
    `CHK(flag, 1'b1)
    wr(IDX_MIN, 8'h42);
    rc(IDX_MIN, 8'h42);
    fresh_read('{8'h00, 8'h42, 8'h10, 8'h83, 8'h15, 8'h06, 8'h10});
  endtask
  task automatic fresh_read(input logic [7:0] e [7]);
    logic [7:0] s0;
    logic [7:0] got [7];
    logic same;
    same = 1'b0;
    while (!same) begin
      rd(IDX_SEC);
      s0 = last_d[7:0];
      for (int k = 1; k < 7; k++) begin
        rd(TIX[k]);
        got[k] = last_d[7:0];
      end
      rd(IDX_SEC);
      same = last_d[7:0] === s0;
    end
    for (int k = 1; k < 7; k++) `CHK(got[k], e[k])
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    reset_case();
    roll(8'h02, '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h00},
      '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h00});
    roll(8'h02, '{8'h59, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h01},
      '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h03, 8'h01});
    roll(8'h02, '{8'h59, 8'h59, 8'h23, 8'h04, 8'h30, 8'h04, 8'h01},
      '{8'h00, 8'h00, 8'h00, 8'h05, 8'h01, 8'h05, 8'h01});
    roll(8'h00, '{8'h59, 8'h59, 8'h91, 8'h01, 8'h31, 8'h12, 8'h99},
      '{8'h00, 8'h00, 8'h12, 8'h02, 8'h01, 8'h01, 8'h00});
    roll(8'h00, '{8'h59, 8'h59, 8'h11, 8'h02, 8'h30, 8'h04, 8'h05},
      '{8'h00, 8'h00, 8'h92, 8'h02, 8'h30, 8'h04, 8'h05});
    alarm_case();
    close_out();
  end
endmodule
bind rtc_calendar_alarm_regs rtc_regs_chk #(.TICK_COUNT(TICK_COUNT)) chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .alarm_flag(alarm_flag));
